//--- inc/srm_pkg.sv
/*
  Shared constants and types for the sixteen-word small storage array.
  Assumes: included before every design file that names srm_pkg.
*/
package srm_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 4;   // Word index width, bit 3 most significant
  localparam int DEPTH     = 16;  // Words held by every form
  localparam int DEF_WIDTH = 1;   // Default word width (1, 2 or 4)
  localparam int INIT_W    = 16;  // One initial bit per word, 1-bit form only

  // ---------------------------------------------------------------
  // Defaults and reset values
  // ---------------------------------------------------------------
  localparam logic [INIT_W-1:0] DEF_INIT = 16'h0000;  // All words start at zero
  localparam logic              WCLK_ACTIVE_HIGH = 1'b0;  // Polarity select value
  localparam logic              WCLK_ACTIVE_LOW  = 1'b1;  // Inverted write clock

  // ---------------------------------------------------------------
  // Write behaviour forms
  // ---------------------------------------------------------------
  typedef enum logic {
    srm_edge_mode,   // Writes on a write clock edge while strobe is high
    srm_level_mode   // Writes every cycle while strobe is high
  } srm_mode_t;

endpackage : srm_pkg

//--- src/srm_store.sv
/*
  Sixteen-word storage with one write port and two combinational read ports.
  Assumes: write enable, index and data are already on ref_clk;
  reset stands in for configuration and loads the initial contents.
*/
`timescale 1ns/1ps
module srm_store #(
  parameter int                           WIDTH = srm_pkg::DEF_WIDTH,
  parameter logic [srm_pkg::INIT_W-1:0]   INIT  = srm_pkg::DEF_INIT
) (
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  input  wire logic                       wr_en,
  input  wire logic [srm_pkg::ADDR_W-1:0] wr_index,
  input  wire logic [WIDTH-1:0]           wr_data,
  input  wire logic [srm_pkg::ADDR_W-1:0] rd_b_index,
  output logic      [WIDTH-1:0]           rd_a_word,
  output logic      [WIDTH-1:0]           rd_b_word
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0]             mem [srm_pkg::DEPTH];       // Word array
  logic [srm_pkg::DEPTH*WIDTH-1:0] mem_flat;                 // Packed view for checks

  // Per-word next value and register
  for (genvar i = 0; i < srm_pkg::DEPTH; i++) begin : g_word
    // Initial bit only for the one-bit form, else zero
    localparam logic [WIDTH-1:0] RST = (WIDTH == 1) ? WIDTH'(INIT[i]) : '0;
    logic [WIDTH-1:0] next_word;                           // Candidate contents

    // Only the write index selects the word; read index never reaches here
    always_comb begin
      next_word = mem[i];
      if (wr_en && (wr_index == srm_pkg::ADDR_W'(i))) begin
        next_word = wr_data;
      end
    end

    // Register the word
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        mem[i] <= RST;
      end else begin
        mem[i] <= next_word;
      end
    end

    assign mem_flat[i*WIDTH +: WIDTH] = mem[i];
  end

  // ---------------------------------------------------------------
  // Combinational reads
  // ---------------------------------------------------------------
  assign rd_a_word = mem[wr_index];
  assign rd_b_word = mem[rd_b_index];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_hold_when_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    !wr_en |=> $stable(mem_flat))
    else $error("stored words changed without a write");

  a_word_stored: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_en |=> (mem[$past(wr_index)] == $past(wr_data)))
    else $error("written word not found at write index");

  a_other_word_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_en && (rd_b_index != wr_index)) |=>
      (mem[$past(rd_b_index)] == $past(rd_b_word)))
    else $error("write disturbed a word it did not address");

endmodule : srm_store

//--- src/srm_top.sv
/*
  Sixteen-word small storage array, edge or level write, with a second
  read port. Pins pass two flip-flops onto ref_clk; outputs are registered.
  Assumes: the user logic holds index and data stable around a write and
  toggles the write clock slower than half the ref_clk rate.
*/
`timescale 1ns/1ps
module srm_top #(
  parameter int                         WIDTH = srm_pkg::DEF_WIDTH,
  parameter srm_pkg::srm_mode_t         MODE  = srm_pkg::srm_edge_mode,
  parameter logic                       WCLK_POL = srm_pkg::WCLK_ACTIVE_HIGH,
  parameter logic [srm_pkg::INIT_W-1:0] INIT  = srm_pkg::DEF_INIT
) (
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  input  wire logic                       wr_clk,
  input  wire logic                       wr_strobe,
  input  wire logic [srm_pkg::ADDR_W-1:0] wr_index,
  input  wire logic [WIDTH-1:0]           wr_data,
  input  wire logic [srm_pkg::ADDR_W-1:0] read_port_index,
  output logic      [WIDTH-1:0]           write_port_read_out,
  output logic      [WIDTH-1:0]           read_port_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic                       wclk_m,   wclk_s;     // Write clock stages
  logic                       strobe_m, strobe_s;   // Strobe stages
  logic [srm_pkg::ADDR_W-1:0] windex_m, windex_s;   // Write index stages
  logic [WIDTH-1:0]           wdata_m,  wdata_s;    // Write data stages
  logic [srm_pkg::ADDR_W-1:0] rindex_m, rindex_s;   // Read index stages
  logic                       wclk_prev;            // Last settled write clock
  logic                       next_wclk_prev;

  // Second stage feeds edge history here and the polarity fold directly
  always_comb begin
    next_wclk_prev = wclk_s;
  end

  // Two flops per pin, all cleared in reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wclk_m    <= 1'b0;
      wclk_s    <= 1'b0;
      strobe_m  <= 1'b0;
      strobe_s  <= 1'b0;
      windex_m  <= '0;
      windex_s  <= '0;
      wdata_m   <= '0;
      wdata_s   <= '0;
      rindex_m  <= '0;
      rindex_s  <= '0;
      wclk_prev <= 1'b0;
    end else begin
      wclk_m    <= wr_clk;
      wclk_s    <= wclk_m;
      strobe_m  <= wr_strobe;
      strobe_s  <= strobe_m;
      windex_m  <= wr_index;
      windex_s  <= windex_m;
      wdata_m   <= wr_data;
      wdata_s   <= wdata_m;
      rindex_m  <= read_port_index;
      rindex_s  <= rindex_m;
      wclk_prev <= next_wclk_prev;
    end
  end

  // ---------------------------------------------------------------
  // Write decision
  // ---------------------------------------------------------------
  logic wclk_eff;       // Write clock after polarity fold
  logic wclk_eff_prev;  // Same, one cycle earlier
  logic active_edge;    // Edge that writes
  logic wr_event;       // Store this cycle

  // Inversion folded in here, not as a separate gate outside
  assign wclk_eff      = wclk_s ^ WCLK_POL;
  assign wclk_eff_prev = wclk_prev ^ WCLK_POL;
  assign active_edge   = wclk_eff && !wclk_eff_prev;

  // Edge form needs strobe plus edge; level form needs strobe only
  always_comb begin
    if (MODE == srm_pkg::srm_level_mode) begin
      wr_event = strobe_s;
    end else begin
      wr_event = strobe_s && active_edge;
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] rd_a_word;  // Word at write index
  logic [WIDTH-1:0] rd_b_word;  // Word at read index

  srm_store #(
    .WIDTH (WIDTH),
    .INIT  (INIT)
  ) u_store (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .wr_en      (wr_event),
    .wr_index   (windex_s),
    .wr_data    (wdata_s),
    .rd_b_index (rindex_s),
    .rd_a_word  (rd_a_word),
    .rd_b_word  (rd_b_word)
  );

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] next_write_port_read_out;
  logic [WIDTH-1:0] next_read_port_out;

  // Write-first on the write port; read port plain lookup
  always_comb begin
    if (wr_event) begin
      next_write_port_read_out = wdata_s;
    end else begin
      next_write_port_read_out = rd_a_word;
    end
    next_read_port_out = rd_b_word;
  end

  // Register both outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      write_port_read_out <= '0;
      read_port_out       <= '0;
    end else begin
      write_port_read_out <= next_write_port_read_out;
      read_port_out       <= next_read_port_out;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_strobe_low_idle: assert property (
    !strobe_s |-> !wr_event)
    else $error("write taken with strobe low");

  a_rise_writes: assert property (
    (MODE == srm_pkg::srm_edge_mode && WCLK_POL == srm_pkg::WCLK_ACTIVE_HIGH
     && strobe_s && wclk_s && !wclk_prev) |-> wr_event)
    else $error("rising edge with strobe did not write");

  a_fall_writes: assert property (
    (MODE == srm_pkg::srm_edge_mode && WCLK_POL == srm_pkg::WCLK_ACTIVE_LOW
     && strobe_s && !wclk_s && wclk_prev) |-> wr_event)
    else $error("falling edge with strobe did not write");

  a_wrong_edge_idle: assert property (
    (MODE == srm_pkg::srm_edge_mode && (wclk_s ^ WCLK_POL) == 1'b0) |-> !wr_event)
    else $error("write on inactive write clock edge");

  a_read_follows: assert property (
    !wr_event |=> (write_port_read_out == $past(rd_a_word)))
    else $error("write port output not the addressed word");

  a_write_first: assert property (
    wr_event |=> (write_port_read_out == $past(wdata_s)))
    else $error("write port output not the written data");

  a_level_writes: assert property (
    (MODE == srm_pkg::srm_level_mode && strobe_s) |-> wr_event)
    else $error("level form did not write with strobe high");

  a_read_port: assert property (
    (read_port_index == rindex_s) [*3] |-> ##1 (read_port_out == $past(rd_b_word)))
    else $error("read port output not the read-indexed word");

  // Both ports read one array, so equal indexes with no write that cycle must give equal words
  a_ports_agree: assert property (
    (rindex_s == windex_s && !wr_event) |=> (read_port_out == write_port_read_out))
    else $error("read port and write port disagree on one word");

  a_pin_delay: assert property (
    ##2 (rindex_s == $past(read_port_index, 2)))
    else $error("read index not two cycles behind its pin");

  c_edge_write:  cover property (wr_event && MODE == srm_pkg::srm_edge_mode);
  c_level_write: cover property (wr_event && MODE == srm_pkg::srm_level_mode);
  c_split_index: cover property (wr_event && (rindex_s != windex_s));
  c_same_index:  cover property (wr_event ##1 (rindex_s == $past(windex_s)));

endmodule : srm_top

//--- test/sixteen_word_small_ram_tb.sv
/*
  Self-checking bench: rising, falling and level forms side by side.
  Assumes: all three arrays share the same user pins.
*/
`timescale 1ns/1ps
module sixteen_word_small_ram_tb;
  localparam logic [15:0] INIT_F = 16'hA5C3;  // Preload of the one-bit array
  logic       ref_clk;      // System clock
  logic       resetn = 1'b0;  // Reset, active low
  logic       wr_clk;       // Write clock pin
  logic       wr_strobe;    // Write strobe pin
  logic [3:0] wr_index;     // Write index pin
  logic [3:0] wr_data;      // Data pin
  logic [3:0] rd_index;     // Read index pin
  logic [3:0] sp_r, dp_r;   // Rising form outputs
  logic       sp_f, dp_f;   // Falling form outputs
  logic [1:0] sp_l, dp_l;   // Level form outputs
  logic [3:0] exp_r [16];   // Expected rising contents
  logic       exp_f [16];   // Expected falling contents
  logic [1:0] exp_l [16];   // Expected level contents
  int         mismatches = 0;
  int         check_count = 0;

  // ---------------------------------------------------------------
  // Clock, partner and arrays
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  srm_user_model u_srm_user_model (.ref_clk(ref_clk), .wr_clk(wr_clk), .wr_strobe(wr_strobe),
    .wr_index(wr_index), .wr_data(wr_data), .read_port_index(rd_index));

  srm_top #(.WIDTH(4), .MODE(srm_pkg::srm_edge_mode), .WCLK_POL(srm_pkg::WCLK_ACTIVE_HIGH))
  u_srm_top_rise (.ref_clk(ref_clk), .resetn(resetn), .wr_clk(wr_clk), .wr_strobe(wr_strobe),
    .wr_index(wr_index), .wr_data(wr_data), .read_port_index(rd_index),
    .write_port_read_out(sp_r), .read_port_out(dp_r));

  srm_top #(.WIDTH(1), .MODE(srm_pkg::srm_edge_mode), .WCLK_POL(srm_pkg::WCLK_ACTIVE_LOW),
    .INIT(INIT_F))
  u_srm_top_fall (.ref_clk(ref_clk), .resetn(resetn), .wr_clk(wr_clk), .wr_strobe(wr_strobe),
    .wr_index(wr_index), .wr_data(wr_data[0]), .read_port_index(rd_index),
    .write_port_read_out(sp_f), .read_port_out(dp_f));

  srm_top #(.WIDTH(2), .MODE(srm_pkg::srm_level_mode))
  u_srm_top_lvl (.ref_clk(ref_clk), .resetn(resetn), .wr_clk(wr_clk), .wr_strobe(wr_strobe),
    .wr_index(wr_index), .wr_data(wr_data[1:0]), .read_port_index(rd_index),
    .write_port_read_out(sp_l), .read_port_out(dp_l));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [3:0] e, input logic [3:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Walk all words on both read ports of every form
  task automatic check_all();
    for (int k = 0; k < 16; k++) begin
      u_srm_user_model.step(1'b0, 1'b0, k[3:0], 4'h0, 4'hF - k[3:0], 6);
      #1;
      cmp("rise_a", exp_r[k], sp_r);
      cmp("rise_b", exp_r[15-k], dp_r);
      cmp("fall_a", {3'h0, exp_f[k]}, {3'h0, sp_f});
      cmp("fall_b", {3'h0, exp_f[15-k]}, {3'h0, dp_f});
      cmp("lvl_a", {2'h0, exp_l[k]}, {2'h0, sp_l});
      cmp("lvl_b", {2'h0, exp_l[15-k]}, {2'h0, dp_l});
    end
  endtask : check_all

  // One write clock pulse, data swapped between its two edges
  task automatic wr_pulse(input logic [3:0] i, input logic [3:0] a, input logic [3:0] b);
    u_srm_user_model.step(1'b0, 1'b1, i, a, ~i, 4);
    u_srm_user_model.step(1'b1, 1'b1, i, a, i ^ 4'h5, 3);
    // Output register loads in the write cycle itself: write-first
    #1;
    cmp("rise_first", a, sp_r);
    repeat (3) @(posedge ref_clk);
    #1;
    cmp("rise_word", a, sp_r);
    u_srm_user_model.step(1'b1, 1'b1, i, b, ~i, 4);
    u_srm_user_model.step(1'b0, 1'b1, i, b, ~i, 6);
    #1;
    cmp("fall_word", {3'h0, b[0]}, {3'h0, sp_f});
    cmp("rise_hold", a, sp_r);
    u_srm_user_model.step(1'b0, 1'b0, i, b, ~i, 4);
    exp_r[i] = a;
    exp_f[i] = b[0];
    exp_l[i] = b[1:0];
  endtask : wr_pulse

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_edges();
    wr_pulse(4'h0, 4'hA, 4'h3);
    wr_pulse(4'hF, 4'h6, 4'hC);
    wr_pulse(4'h8, 4'h1, 4'hE);
    wr_pulse(4'h5, 4'h9, 4'h4);
    check_all();
  endtask : t_edges

  // Clock toggles and pin changes with the strobe low
  task automatic t_strobe_low();
    u_srm_user_model.step(1'b1, 1'b0, 4'h0, 4'h5, 4'h1, 6);
    u_srm_user_model.step(1'b0, 1'b0, 4'hF, 4'h2, 4'h2, 6);
    u_srm_user_model.step(1'b1, 1'b0, 4'h5, 4'hB, 4'h3, 6);
    u_srm_user_model.step(1'b0, 1'b0, 4'h8, 4'h0, 4'h4, 6);
    check_all();
  endtask : t_strobe_low

  // Strobe high with no write clock edge
  task automatic t_level();
    u_srm_user_model.step(1'b0, 1'b1, 4'h7, 4'h9, 4'h0, 6);
    u_srm_user_model.step(1'b0, 1'b1, 4'h2, 4'h6, 4'h0, 6);
    #1;
    cmp("lvl_live", 4'h2, {2'h0, sp_l});
    u_srm_user_model.step(1'b0, 1'b0, 4'h2, 4'h6, 4'h0, 4);
    exp_l[7] = 2'h1;
    exp_l[2] = 2'h2;
    check_all();
  endtask : t_level

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    for (int k = 0; k < 16; k++) begin
      exp_r[k] = 4'h0;
      exp_f[k] = INIT_F[k];
      exp_l[k] = 2'h0;
    end
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    check_all();
    t_edges();
    t_strobe_low();
    t_level();
    close_out();
  end

  // Run needs about 620 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
endmodule : sixteen_word_small_ram_tb

//--- test/srm_user_model.sv
/*
  Behavioural user logic that drives the storage array pins.
  Assumes: only one bench process calls step at a time.
*/
`timescale 1ns/1ps
module srm_user_model (
  input  wire logic       ref_clk,
  output logic            wr_clk,
  output logic            wr_strobe,
  output logic [3:0]      wr_index,
  output logic [3:0]      wr_data,
  output logic [3:0]      read_port_index
);
  // ---------------------------------------------------------------
  // Pin driver
  // ---------------------------------------------------------------
  // Idle pins from time zero
  initial begin
    wr_clk = 1'b0;
    wr_strobe = 1'b0;
    wr_index = 4'h0;
    wr_data = 4'h0;
    read_port_index = 4'h0;
  end

  // Update pins after an edge, then hold them for n cycles
  task automatic step(input logic c, input logic s, input logic [3:0] i,
                      input logic [3:0] d, input logic [3:0] r, input int n);
    @(posedge ref_clk);
    wr_clk <= c;
    wr_strobe <= s;
    wr_index <= i;
    wr_data <= d;
    read_port_index <= r;
    repeat (n) @(posedge ref_clk);
  endtask : step
endmodule : srm_user_model
